/* File: hdl/sdrca_top.v */
// Lane alignment sequencer and per-lane aligner with AXI4-Lite access.
// Assumes CLK_I is the received link clock divided by four, and
// LANE_SAMPLE_I are lane samples taken on one fixed receive clock edge.
`timescale 1ns/10ps
`include "sdrca_map.vh"

module sdrca_top #(
  parameter LANES   = `SDRCA_LANE_TOTAL,
  parameter TAP_MAX = `SDRCA_TAP_MAX,
  parameter SETTLE  = `SDRCA_SETTLE
) (
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire [15:0] LANE_SAMPLE_I,
  output reg  [15:0] DELAY_STEP_O,
  output reg  [15:0] DELAY_UP_O,
  output reg         CLOCK_PATTERN_REQ_O,
  output reg         LANE_DONE_O,
  output reg         BEGIN_LANE_ALIGN_O,
  output reg  [4:0]  LANES_LOCKED_O,
  output reg         ALL_ALIGNED_O,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  // ****************************************************************
  // Local states
  // ****************************************************************
  localparam A_IDLE   = 3'd0;
  localparam A_RISE   = 3'd1;
  localparam A_FALL   = 3'd2;
  localparam A_BACK   = 3'd3;
  localparam A_FINISH = 3'd4;
  localparam A_STUCK  = 3'd5;

  // ****************************************************************
  // Sample synchronisers
  // ****************************************************************
  reg [15:0] smp1;
  reg [15:0] smp2;
  reg [15:0] smp3;
  reg [15:0] smp_ok;

  // A lane level counts only once the second and third stages agree.
  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      smp1   <= 16'h0000;
      smp2   <= 16'h0000;
      smp3   <= 16'h0000;
      smp_ok <= 16'h0000;
    end
    else
    begin
      smp1 <= LANE_SAMPLE_I;
      smp2 <= smp1;
      smp3 <= smp2;
      smp_ok <= (smp2 & smp3) | (smp_ok & (smp2 ^ smp3));
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  reg        start_req;
  reg        go;
  reg  [1:0] seq_state;
  reg  [2:0] al_state;
  reg  [5:0] tap;
  reg  [5:0] width;
  reg  [3:0] settle;
  reg        prev;
  reg        have_prev;
  wire [3:0] lane = LANES_LOCKED_O[3:0];
  wire       cur = smp_ok[lane];

  // ****************************************************************
  // Lane sequencer
  // ****************************************************************
  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      seq_state          <= `SDRCA_SEQ_IDLE;
      LANES_LOCKED_O     <= 5'h00;
      BEGIN_LANE_ALIGN_O <= 1'b0;
      ALL_ALIGNED_O      <= 1'b0;
    end
    else
    begin
      BEGIN_LANE_ALIGN_O <= 1'b0;
      ALL_ALIGNED_O <= (LANES_LOCKED_O == LANES[4:0]);
      case (seq_state)
        `SDRCA_SEQ_IDLE:
          if (go)
          begin
            seq_state          <= `SDRCA_SEQ_ALIGN;
            BEGIN_LANE_ALIGN_O <= 1'b1;
          end
        `SDRCA_SEQ_ALIGN:
          if (LANE_DONE_O && al_state == A_FINISH)
          begin
            LANES_LOCKED_O <= LANES_LOCKED_O + 5'h01;
            if (LANES_LOCKED_O != LANES[4:0] - 5'h01)
            begin
              BEGIN_LANE_ALIGN_O <= 1'b1;
            end
            else
            begin
              seq_state <= `SDRCA_SEQ_DONE;
            end
          end
        `SDRCA_SEQ_DONE:
          if (go)
          begin
            LANES_LOCKED_O     <= 5'h00;
            seq_state          <= `SDRCA_SEQ_ALIGN;
            BEGIN_LANE_ALIGN_O <= 1'b1;
          end
        default:
          seq_state <= `SDRCA_SEQ_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Per-lane aligner
  // ****************************************************************
  // Each rising and falling search step waits SETTLE cycles plus four for the sampler pipeline; back steps do not wait.
  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      al_state            <= A_IDLE;
      tap                 <= 6'h00;
      width               <= 6'h00;
      settle              <= 4'h0;
      prev                <= 1'b0;
      have_prev           <= 1'b0;
      DELAY_STEP_O        <= 16'h0000;
      DELAY_UP_O          <= 16'h0000;
      CLOCK_PATTERN_REQ_O <= 1'b0;
      LANE_DONE_O         <= 1'b0;
    end
    else
    begin
      DELAY_STEP_O <= 16'h0000;
      LANE_DONE_O  <= 1'b0;
      if (settle != 4'h0)
        settle <= settle - 4'h1;
      case (al_state)
        A_IDLE:
          if (BEGIN_LANE_ALIGN_O)
          begin
            CLOCK_PATTERN_REQ_O <= 1'b1;
            al_state  <= A_RISE;
            tap       <= 6'h00;
            width     <= 6'h00;
            have_prev <= 1'b0;
            settle    <= SETTLE[3:0] + 4'h4;
          end
        A_RISE, A_FALL:
          if (settle == 4'h0)
          begin
            prev      <= cur;
            have_prev <= 1'b1;
            if (have_prev && al_state == A_RISE && !prev && cur)
            begin
              al_state <= A_FALL;
            end
            else if (have_prev && al_state == A_FALL && prev && !cur)
            begin
              al_state <= A_BACK;
              settle   <= 4'h0;
            end
            else if (tap == TAP_MAX[5:0])
            begin
              al_state <= A_STUCK;
            end
            if (!(have_prev && al_state == A_FALL && prev && !cur) &&
                tap != TAP_MAX[5:0])
            begin
              tap                <= tap + 6'h01;
              DELAY_STEP_O[lane] <= 1'b1;
              DELAY_UP_O[lane]   <= 1'b1;
              settle             <= SETTLE[3:0] + 4'h4;
              if (al_state == A_FALL || (have_prev && !prev && cur))
                width <= width + 6'h01;
            end
          end
        A_BACK:
          if (width[5:1] != 5'h00)
          begin
            width              <= width - 6'h02;
            tap                <= tap - 6'h01;
            DELAY_STEP_O[lane] <= 1'b1;
            DELAY_UP_O[lane]   <= 1'b0;
          end
          else
          begin
            al_state    <= A_FINISH;
            LANE_DONE_O <= 1'b1;
          end
        A_FINISH:
          begin
            al_state <= A_IDLE;
            if (lane == 4'hf || LANES_LOCKED_O + 5'h01 == LANES[4:0])
              CLOCK_PATTERN_REQ_O <= 1'b0;
          end
        A_STUCK:
          al_state <= A_STUCK;
        default:
          al_state <= A_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg        aw_hold;
  reg        w_hold;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `SDRCA_RESP_OKAY;
      start_req     <= `SDRCA_CTRL_RESET;
      go            <= 1'b0;
    end
    else
    begin
      go            <= 1'b0;
      S_AXI_AWREADY <= !aw_hold && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_hold && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold       <= 1'b1;
        aw_addr       <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold       <= 1'b1;
        w_data       <= S_AXI_WDATA;
        w_strb       <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (aw_hold && w_hold && !S_AXI_BVALID)
      begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= `SDRCA_RESP_OKAY;
        if (aw_addr == `SDRCA_CTRL_ADDR)
        begin
          if (w_strb[0])
          begin
            start_req <= w_data[`SDRCA_CTRL_START];
            go        <= w_data[`SDRCA_CTRL_START];
          end
        end
        else if (aw_addr != `SDRCA_STATUS_ADDR &&
                 aw_addr != `SDRCA_TAP_ADDR &&
                 aw_addr != `SDRCA_WIDTH_ADDR)
          S_AXI_BRESP <= `SDRCA_RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `SDRCA_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= `SDRCA_RESP_OKAY;
        S_AXI_RDATA   <= 32'h00000000;
        case (S_AXI_ARADDR)
          `SDRCA_CTRL_ADDR:
            S_AXI_RDATA[`SDRCA_CTRL_START] <= start_req;
          `SDRCA_STATUS_ADDR:
          begin
            S_AXI_RDATA[`SDRCA_ST_ALIGNED] <= ALL_ALIGNED_O;
            S_AXI_RDATA[`SDRCA_ST_REQ]     <= CLOCK_PATTERN_REQ_O;
            S_AXI_RDATA[`SDRCA_ST_STUCK]   <= (al_state == A_STUCK);
            S_AXI_RDATA[`SDRCA_ST_LOCK_LSB+4:`SDRCA_ST_LOCK_LSB] <=
              LANES_LOCKED_O;
          end
          `SDRCA_TAP_ADDR:
            S_AXI_RDATA[5:0] <= tap;
          `SDRCA_WIDTH_ADDR:
            S_AXI_RDATA[5:0] <= width;
          default:
            S_AXI_RRESP <= `SDRCA_RESP_SLVERR;
        endcase
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

/* File: pkg/sdrca_map.vh */
// Constants for the SDR lane alignment block: states, codes and defaults.
// Assumes inclusion by bare name from the design files.
`ifndef SDRCA_MAP_VH
`define SDRCA_MAP_VH

// ****************************************************************
// AXI4-Lite register offsets
// ****************************************************************
`define SDRCA_CTRL_ADDR    8'h00
`define SDRCA_STATUS_ADDR  8'h04
`define SDRCA_TAP_ADDR     8'h08
`define SDRCA_WIDTH_ADDR   8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define SDRCA_CTRL_START   0
`define SDRCA_ST_ALIGNED   0
`define SDRCA_ST_REQ       1
`define SDRCA_ST_STUCK     2
`define SDRCA_ST_LOCK_LSB  8

// ****************************************************************
// Reset values, encodings and parameter defaults
// ****************************************************************
`define SDRCA_CTRL_RESET   1'b0
`define SDRCA_SEQ_IDLE     2'b00
`define SDRCA_SEQ_ALIGN    2'b01
`define SDRCA_SEQ_DONE     2'b10
`define SDRCA_LANE_TOTAL   16
`define SDRCA_TAP_MAX      63
`define SDRCA_SETTLE       4
`define SDRCA_RESP_OKAY    2'b00
`define SDRCA_RESP_SLVERR  2'b10

`endif

/* File: verification/sdrca_top_assertions.sv */
// Checker on the sequencer and per-lane aligner outputs of sdrca_top.
// Assumes binding to sdrca_top, seeing its ports only.
`timescale 1ns/10ps
module sdrca_top_chk #(
  parameter LANES = 16
) (
  input wire        CLK_I,
  input wire        RESET_I,
  input wire [15:0] DELAY_STEP_O,
  input wire        CLOCK_PATTERN_REQ_O,
  input wire        LANE_DONE_O,
  input wire        BEGIN_LANE_ALIGN_O,
  input wire [4:0]  LANES_LOCKED_O,
  input wire        ALL_ALIGNED_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  property p_count;
    LANE_DONE_O |=> LANES_LOCKED_O == $past(LANES_LOCKED_O) + 5'h01;
  endproperty
  a_count: assert property (p_count) else $error("count step");
  property p_begin;
    LANE_DONE_O && LANES_LOCKED_O != LANES - 1 |=> BEGIN_LANE_ALIGN_O;
  endproperty
  a_begin: assert property (p_begin) else $error("no begin");
  property p_all;
    1'b1 |=> ALL_ALIGNED_O == ($past(LANES_LOCKED_O) == LANES);
  endproperty
  a_all: assert property (p_all) else $error("all flag");
  property p_lane;
    |DELAY_STEP_O |-> DELAY_STEP_O == 16'h0001 << LANES_LOCKED_O;
  endproperty
  a_lane: assert property (p_lane) else $error("wrong lane");
  property p_req;
    |DELAY_STEP_O |-> CLOCK_PATTERN_REQ_O;
  endproperty
  a_req: assert property (p_req) else $error("step no req");
  property p_begin_req;
    BEGIN_LANE_ALIGN_O |-> ##[1:2] CLOCK_PATTERN_REQ_O;
  endproperty
  a_begin_req: assert property (p_begin_req) else $error("req late");
  property p_pulse;
    LANE_DONE_O |=> !LANE_DONE_O;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done long");
  property p_lim;
    LANE_DONE_O |-> LANES_LOCKED_O < LANES;
  endproperty
  a_lim: assert property (p_lim) else $error("done past last");
  property p_idle;
    ALL_ALIGNED_O |-> DELAY_STEP_O == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("step when done");
  property p_rst;
    $fell(RESET_I) |-> LANES_LOCKED_O == 5'h00 && !ALL_ALIGNED_O;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_done: cover property (LANE_DONE_O);
  c_all: cover property (ALL_ALIGNED_O);
  c_down: cover property (|DELAY_STEP_O ##1 LANE_DONE_O);
endmodule
bind sdrca_top sdrca_top_chk #(.LANES(LANES)) u_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .DELAY_STEP_O(DELAY_STEP_O),
  .CLOCK_PATTERN_REQ_O(CLOCK_PATTERN_REQ_O), .LANE_DONE_O(LANE_DONE_O),
  .BEGIN_LANE_ALIGN_O(BEGIN_LANE_ALIGN_O),
  .LANES_LOCKED_O(LANES_LOCKED_O), .ALL_ALIGNED_O(ALL_ALIGNED_O));

/* File: verification/sdrca_tx_model.sv */
// Far-side transmitter and lane delay lines seen by the aligner.
// Assumes one clock; each lane has an offset of 0 to 19 taps.
`timescale 1ns/10ps
module sdrca_tx_model (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         req_i,
  input  wire [15:0]  step_i,
  input  wire [15:0]  up_i,
  input  wire [79:0]  offs_i,
  output reg  [15:0]  sample_o,
  output reg  [111:0] taps_o
);
  integer   l;
  integer   ph;
  reg [6:0] t;
  // Toggling pattern gives a 10-tap window every 20 taps of delay.
  always @(posedge clk_i)
  begin
    for (l = 0; l < 16; l = l + 1)
    begin
      t = rst_i ? 7'h00 : taps_o[l*7+:7];
      if (step_i[l])
        t = up_i[l] ? t + 7'h01 : t - 7'h01;
      taps_o[l*7+:7] <= t;
      ph = (t + offs_i[l*5+:5]) % 20;
      sample_o[l] <= rst_i ? 1'b0 : req_i ? (ph >= 10) : ~sample_o[l];
    end
  end
endmodule

/* File: verification/sdr_channel_alignment_test.sv */
// Self-checking bench for sdrca_top with a transmitter model.
// Assumes the register map and codes of sdrca_map.vh.
`timescale 1ns/10ps
`include "sdrca_map.vh"
module sdr_channel_alignment_test;
  reg          clk, rst, awv, wv, br, arv, rr;
  reg  [7:0]   awa, ara;
  reg  [31:0]  wd, rd;
  reg  [1:0]   resp;
  reg  [79:0]  offs;
  wire [15:0]  smp, stp, up;
  wire [111:0] taps;
  wire         req, awr, wr, bv, arr, rv;
  wire [1:0]   bre, rre;
  wire [31:0]  rda;
  wire [4:0]   lck;
  wire         all;
  integer      seed, fails, n_tests, cyc, i;
  sdrca_tx_model u_tx (.clk_i(clk), .rst_i(rst), .req_i(req),
    .step_i(stp), .up_i(up), .offs_i(offs), .sample_o(smp), .taps_o(taps));
  sdrca_top DUT (.CLK_I(clk), .RESET_I(rst), .LANE_SAMPLE_I(smp),
    .DELAY_STEP_O(stp), .DELAY_UP_O(up), .CLOCK_PATTERN_REQ_O(req),
    .LANE_DONE_O(), .BEGIN_LANE_ALIGN_O(), .LANES_LOCKED_O(lck),
    .ALL_ALIGNED_O(all), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bre),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rda),
    .S_AXI_RRESP(rre), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
  // Centre tap: rising edge tap plus half of the 10-tap window.
  function [31:0] centre(input [4:0] o);
    centre = (o < 10 ? 10 - o : 30 - o) + 5;
  endfunction
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
  begin
    n_tests = n_tests + 1;
    if (e !== g)
    begin
      fails = fails + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task axw(input [7:0] a, input [31:0] d);
  begin
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      resp = bre;
    end while (!bv);
    br <= 1'b0;
    @(posedge clk);
  end
  endtask
  task axr(input [7:0] a);
  begin
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      resp = rre;
      rd = rda;
    end while (!rv);
    rr <= 1'b0;
    @(posedge clk);
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial
  begin
    seed = 94; fails = 0; n_tests = 0; cyc = 0; rst = 1'b1;
    awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0;
    offs[9:0] = {5'd10, 5'd9};
    for (i = 2; i < 16; i = i + 1)
      offs[i*5+:5] = $unsigned($random(seed)) % 20;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(`SDRCA_STATUS_ADDR);
    chk("status", 32'h0, rd);
    axr(8'h10);
    chk("rresp", `SDRCA_RESP_SLVERR, resp);
    chk("rdata", 32'h0, rd);
    $display("test reset and map done");
    axw(`SDRCA_CTRL_ADDR, 32'h1);
    chk("bresp", `SDRCA_RESP_OKAY, resp);
    while (all !== 1'b1)
      @(posedge clk);
    for (i = 0; i < 16; i = i + 1)
      chk("tap", centre(offs[i*5+:5]), taps[i*7+:7]);
    chk("locked", 32'd16, lck);
    axr(`SDRCA_STATUS_ADDR);
    chk("status", 32'h1001, rd);
    axr(`SDRCA_CTRL_ADDR);
    chk("ctrl", 32'h1, rd);
    axr(`SDRCA_TAP_ADDR);
    chk("tapreg", centre(offs[75+:5]), rd);
    axr(`SDRCA_WIDTH_ADDR);
    chk("widthreg", 32'h0, rd);
    $display("test sweep done");
    end_of_test;
  end
endmodule
